//--- rtl/btg_pkg.sv
// package of constants, types and helpers for the buzzer tone generator
package btg_pkg;
  localparam logic [15:0] CTRL_ADDR = 16'hff44;
  localparam logic [15:0] FREQ_ADDR = 16'hff45;
  localparam logic [15:0] STAT_ADDR = 16'hff46;
  localparam logic [15:0] MASK_ADDR = 16'hff47;
  localparam int TONE_EN_BIT = 0;
  localparam int ENV_EN_BIT = 1;
  localparam int ENV_RESTART_BIT = 2;
  localparam int ENV_DECAY_BIT = 3;
  localparam int OS_LEN_BIT = 4;
  localparam int OS_TRIG_BIT = 5;
  localparam int OS_STOP_BIT = 6;
  localparam int FREQ_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam int EV_OS_END_BIT = 0;
  localparam int EV_ENV_END_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FREQ_RESET = 8'h00;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // timing: tick runs at twice the low-speed oscillator rate
  localparam int CORE_HZ = 20000000;
  localparam int OSC_HZ = 32768;
  localparam int TICK_HZ = 2 * OSC_HZ;
  localparam longint US_PER_S = 1000000;
  localparam longint OS_LONG_US = 125000;
  localparam longint OS_SHORT_US = 31250;
  localparam longint DECAY_LONG_US = 1000000;
  localparam longint DECAY_SHORT_US = 500000;
  localparam int ENV_STEPS = 8;
  localparam logic [2:0] ENV_MAX = 3'h7;
  localparam int OS_LONG_TICKS = int'(OS_LONG_US * TICK_HZ / US_PER_S);
  localparam int OS_SHORT_TICKS = int'(OS_SHORT_US * TICK_HZ / US_PER_S);
  localparam int DECAY_LONG_STEP = int'(DECAY_LONG_US * TICK_HZ / US_PER_S) / ENV_STEPS;
  localparam int DECAY_SHORT_STEP = int'(DECAY_SHORT_US * TICK_HZ / US_PER_S) / ENV_STEPS;
  localparam logic [4:0] HIGH_BASE_LOW = 5'h08;
  localparam logic [4:0] HIGH_BASE_HIGH = 5'h0c;

  typedef enum logic {OS_READY = 1'b0, OS_BUSY = 1'b1} btg_os_state_type;

  // period in half-oscillator units: 16, 20, 24, 28
  function automatic logic [4:0] btg_period(input logic [2:0] freq);
    btg_period = 5'h10 + {1'b0, freq[1:0], 2'b00};
  endfunction : btg_period

  // high time: 8 or 12 units less one per duty step
  function automatic logic [4:0] btg_high(input logic [2:0] freq, input logic [2:0] duty);
    btg_high = (freq[1] ? HIGH_BASE_HIGH : HIGH_BASE_LOW) - {2'b00, duty};
  endfunction : btg_high
endpackage : btg_pkg

//--- rtl/btg_tone_gen.sv
// square wave generator with selectable period and high time
`timescale 1ns/1ps
module btg_tone_gen import btg_pkg::*; (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [2:0] freq_code_in,
  input wire logic [2:0] duty_code_in,
  output logic wave_out
);
  logic phase;
  logic armed;
  logic [4:0] count;
  wire logic unit_tick = tick_in & (~freq_code_in[2] | phase);
  wire logic [4:0] period = btg_period(freq_code_in);
  wire logic [4:0] high = btg_high(freq_code_in, duty_code_in);
  // a period change mid-run wraps at once instead of running to 31
  wire logic last = (count >= period - 5'h01);
  wire logic [4:0] next_count = last ? 5'h00 : count + 5'h01;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase <= 1'b0;
      armed <= 1'b0;
      count <= 5'h00;
      wave_out <= 1'b0;
    end else if (!run_in) begin
      phase <= 1'b0;
      armed <= 1'b0;
      count <= 5'h00;
      wave_out <= 1'b0;
    end else begin
      phase <= phase ^ tick_in;
      // start on a unit boundary so the first period is full length
      if (!armed) begin
        if (unit_tick) armed <= 1'b1;
        wave_out <= 1'b0;
      end else begin
        if (unit_tick) count <= next_count;
        wave_out <= (count < high);
      end
    end
  end

  a_count_range: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    count < period |=> count < period || $changed(freq_code_in))
    else $error("tone counter beyond period");
endmodule : btg_tone_gen

//--- rtl/btg_top.sv
// buzzer tone generator: registers, one-shot, envelope and pin drive
//
// Behaviour
// - frequency code divides oscillator by 8..28
// - duty code sets high time, one less per step
// - codes zero give 4096 Hz; code 100 2048 Hz
// - tone enable starts and stops tone, resets clear
// - trigger write starts one-shot; read shows busy
// - length select: 125 ms or 31.25 ms
// - forced stop write ends running one-shot
// - decay select: 1 s or 0.5 s
// - restart write restarts envelope, reads zero
// - envelope enable, forced off during one-shot
`timescale 1ns/1ps
module btg_top import btg_pkg::*; #(
  parameter int OS_LONG = OS_LONG_TICKS,
  parameter int OS_SHORT = OS_SHORT_TICKS,
  parameter int STEP_LONG = DECAY_LONG_STEP,
  parameter int STEP_SHORT = DECAY_SHORT_STEP
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [15:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic SHARED_OUTPUT_PORT_IN,
  output logic [7:0] RDATA_OUT,
  output logic SHARED_OUTPUT_PIN_OUT,
  output logic IRQ_OUT
);
  // oscillator tick by phase accumulation, exact on average
  logic [24:0] osc_acc;
  wire logic [24:0] acc_sum = osc_acc + 25'(TICK_HZ);
  wire logic tick = (acc_sum >= 25'(CORE_HZ));
  wire logic [24:0] next_osc_acc = tick ? acc_sum - 25'(CORE_HZ) : acc_sum;

  // software-visible and internal state
  logic tone_en;
  logic env_en;
  logic env_decay;
  logic os_len;
  logic [2:0] freq_code;
  logic [2:0] duty_code;
  logic [1:0] stat;
  logic [1:0] mask;
  btg_os_state_type os_state;
  logic [13:0] os_cnt;
  logic os_long_run;
  logic [2:0] env_level;
  logic [13:0] env_cnt;
  logic sounding_q;

  // bus decode
  wire logic sel_ctrl = (ADDR_IN == CTRL_ADDR);
  wire logic sel_freq = (ADDR_IN == FREQ_ADDR);
  wire logic sel_stat = (ADDR_IN == STAT_ADDR);
  wire logic sel_mask = (ADDR_IN == MASK_ADDR);
  wire logic wr_ctrl = WR_IN & sel_ctrl;
  wire logic wr_freq = WR_IN & sel_freq;
  wire logic wr_mask = WR_IN & sel_mask;
  wire logic rd_stat = RD_IN & sel_stat;

  // one-shot control; a stop beside a trigger wins
  wire logic os_busy = (os_state == OS_BUSY);
  wire logic os_stop = wr_ctrl & WDATA_IN[OS_STOP_BIT];
  wire logic os_start = wr_ctrl & WDATA_IN[OS_TRIG_BIT] & ~os_busy & ~os_stop;
  wire logic [13:0] os_limit = os_long_run ? 14'(OS_LONG) : 14'(OS_SHORT);
  wire logic os_expire = os_busy & tick & (os_cnt == os_limit - 14'h0001);
  wire logic os_end = os_busy & (os_expire | os_stop);

  // envelope, held off while a one-shot sounds
  wire logic sounding = tone_en | os_busy;
  wire logic env_active = env_en & ~os_busy & sounding;
  wire logic env_restart = wr_ctrl & WDATA_IN[ENV_RESTART_BIT];
  wire logic tone_start = sounding & ~sounding_q;
  wire logic [13:0] env_step = env_decay ? 14'(STEP_LONG) : 14'(STEP_SHORT);
  // a decay change mid-step cannot strand the step counter
  wire logic env_adv = env_active & tick & (env_cnt >= env_step - 14'h0001);
  wire logic env_reach = env_adv & (env_level == ENV_MAX - 3'h1);
  wire logic [3:0] duty_sum = {1'b0, duty_code} + {1'b0, env_active ? env_level : 3'h0};
  wire logic [2:0] duty_eff = duty_sum[3] ? ENV_MAX : duty_sum[2:0];

  // events into sticky status; set wins over read clear
  wire logic [1:0] events = {env_reach, os_end};
  wire logic [1:0] next_stat = (rd_stat ? 2'h0 : stat) | events;

  // read data
  wire logic [7:0] ctrl_view = {1'b0, 1'b0, os_busy, os_len, env_decay, 1'b0, env_en, tone_en};
  wire logic [7:0] freq_view = {1'b0, duty_code, 1'b0, freq_code};
  wire logic [7:0] next_rdata =
    sel_ctrl ? ctrl_view :
    sel_freq ? freq_view :
    sel_stat ? {6'h00, stat} :
    sel_mask ? {6'h00, mask} : UNMAPPED_READ;

  wire logic wave;

  btg_tone_gen u_tone (
    .clk_in(CORE_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .tick_in(tick),
    .run_in(sounding),
    .freq_code_in(freq_code),
    .duty_code_in(duty_eff),
    .wave_out(wave)
  );

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) osc_acc <= 25'h0;
    else osc_acc <= next_osc_acc;
  end

  // control register fields
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      tone_en <= CTRL_RESET[TONE_EN_BIT];
      env_en <= CTRL_RESET[ENV_EN_BIT];
      env_decay <= CTRL_RESET[ENV_DECAY_BIT];
      os_len <= CTRL_RESET[OS_LEN_BIT];
    end else begin
      if (wr_ctrl) begin
        tone_en <= WDATA_IN[TONE_EN_BIT];
        env_decay <= WDATA_IN[ENV_DECAY_BIT];
        os_len <= WDATA_IN[OS_LEN_BIT];
      end
      // forced low once a one-shot begins and while it runs
      if (os_busy | os_start) env_en <= 1'b0;
      else if (wr_ctrl) env_en <= WDATA_IN[ENV_EN_BIT];
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      freq_code <= FREQ_RESET[FREQ_LSB +: 3];
      duty_code <= FREQ_RESET[DUTY_LSB +: 3];
    end else if (wr_freq) begin
      freq_code <= WDATA_IN[FREQ_LSB +: 3];
      duty_code <= WDATA_IN[DUTY_LSB +: 3];
    end
  end

  // one-shot state machine
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      os_state <= OS_READY;
      os_cnt <= 14'h0;
      os_long_run <= CTRL_RESET[OS_LEN_BIT];
    end else begin
      unique case (os_state)
        OS_READY: begin
          os_cnt <= 14'h0;
          if (os_start) begin
            os_state <= OS_BUSY;
            // length fixed per run, a later write cannot strand the counter
            os_long_run <= WDATA_IN[OS_LEN_BIT];
          end
        end
        OS_BUSY: begin
          if (os_end) begin
            os_state <= OS_READY;
            os_cnt <= 14'h0;
          end else if (tick) begin
            os_cnt <= os_cnt + 14'h0001;
          end
        end
      endcase
    end
  end

  // envelope stepping; limitation: a level change lands mid-period
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      env_level <= 3'h0;
      env_cnt <= 14'h0;
      sounding_q <= 1'b0;
    end else begin
      sounding_q <= sounding;
      if (env_restart | tone_start) begin
        env_level <= 3'h0;
        env_cnt <= 14'h0;
      end else if (env_active & tick & env_level != ENV_MAX) begin
        if (env_adv) begin
          env_level <= env_level + 3'h1;
          env_cnt <= 14'h0;
        end else begin
          env_cnt <= env_cnt + 14'h0001;
        end
      end
    end
  end

  // status, mask, interrupt
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stat <= STAT_RESET;
      mask <= MASK_RESET;
    end else begin
      stat <= next_stat;
      if (wr_mask) mask <= WDATA_IN[1:0];
    end
  end

  assign IRQ_OUT = |(stat & mask);

  // read data and pin are registered
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RDATA_OUT <= 8'h00;
      SHARED_OUTPUT_PIN_OUT <= 1'b0;
    end else begin
      RDATA_OUT <= RD_IN ? next_rdata : 8'h00;
      // port bit low keeps the pin a plain low output
      SHARED_OUTPUT_PIN_OUT <= SHARED_OUTPUT_PORT_IN & wave;
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_freq_read_zero: assert property (
    RD_IN && sel_freq |=> RDATA_OUT[7] == 1'b0 && RDATA_OUT[3] == 1'b0)
    else $error("unused frequency bits not zero");

  a_ctrl_read_zero: assert property (
    RD_IN && sel_ctrl |=> RDATA_OUT[7:6] == 2'b00 && RDATA_OUT[2] == 1'b0)
    else $error("write-only control bits read nonzero");

  a_busy_reads: assert property (
    RD_IN && sel_ctrl |=> RDATA_OUT[OS_TRIG_BIT] == $past(os_busy))
    else $error("busy bit readback wrong");

  a_trigger_starts: assert property (
    wr_ctrl && WDATA_IN[OS_TRIG_BIT] && !WDATA_IN[OS_STOP_BIT] && !os_busy
    |=> os_busy ##1 (os_busy || $past(os_end)))
    else $error("trigger did not start one-shot");

  a_zero_no_trigger: assert property (
    !os_busy && !(wr_ctrl && WDATA_IN[OS_TRIG_BIT]) |=> !os_busy)
    else $error("one-shot started without trigger");

  a_stop_ends: assert property (
    os_busy && wr_ctrl && WDATA_IN[OS_STOP_BIT] |=> !os_busy && stat[EV_OS_END_BIT])
    else $error("forced stop did not end one-shot");

  a_os_bound: assert property (
    os_busy |-> os_cnt < os_limit)
    else $error("one-shot ran past its length");

  a_env_forced: assert property (
    os_busy |=> !env_en)
    else $error("envelope enable set during one-shot");

  a_tone_enable: assert property (
    wr_ctrl && !WDATA_IN[TONE_EN_BIT] && !os_busy && !os_start |=> !sounding ##2 !wave)
    else $error("tone still running after disable");

  a_restart: assert property (
    env_restart |=> env_level == 3'h0 && env_cnt == 14'h0)
    else $error("envelope restart not applied");

  a_env_hold: assert property (
    env_level == ENV_MAX && !env_restart && !tone_start |=> env_level == ENV_MAX)
    else $error("envelope left its floor");

  a_pin_gated: assert property (
    !SHARED_OUTPUT_PORT_IN |=> !SHARED_OUTPUT_PIN_OUT)
    else $error("tone on pin with port bit low");

  a_stat_sticky: assert property (
    stat[EV_OS_END_BIT] && !rd_stat |=> stat[EV_OS_END_BIT])
    else $error("status bit lost without read");
endmodule : btg_top

//--- test/btg_buzzer_model.sv
// piezo drive model: measures tone period and high time seen on the pin
`timescale 1ns/1ps
module btg_buzzer_model (
  input wire logic clk_in,
  input wire logic pin_in,
  output int period_out,
  output int high_out,
  output int rises_out
);
  logic prev = 1'b0;
  int cnt = 0;
  int hcnt = 0;
  int period = 0;
  int high = 0;
  int rises = 0;
  assign period_out = period;
  assign high_out = high;
  assign rises_out = rises;
  // a piezo only follows edges, so the period is taken rise to rise
  always @(posedge clk_in) begin
    prev <= pin_in;
    if (pin_in === 1'b1 && prev === 1'b0) begin
      period <= cnt;
      high <= hcnt;
      rises <= rises + 1;
      cnt <= 1;
      hcnt <= 1;
    end else begin
      cnt <= cnt + 1;
      hcnt <= hcnt + ((pin_in === 1'b1) ? 1 : 0);
    end
  end
endmodule : btg_buzzer_model

//--- test/tb_buzzer_tone_generator.sv
// testbench for the buzzer tone generator: registers, tone, one-shot, envelope
`timescale 1ns/1ps
module tb_buzzer_tone_generator import btg_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic port = 1'b0;
  wire [7:0] rdata;
  wire pin;
  wire irq;
  int period, high, rises, n, r0;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int dv [8] = '{8, 10, 12, 14, 16, 20, 24, 28};
  logic [7:0] d;

  always #25 clk = ~clk;

  // short one-shot and envelope counts keep the run near 110k cycles
  btg_top #(.OS_LONG(8), .OS_SHORT(2), .STEP_LONG(3), .STEP_SHORT(2)) btg_top_i (
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr_s), .RD_IN(rd_s), .SHARED_OUTPUT_PORT_IN(port), .RDATA_OUT(rdata),
    .SHARED_OUTPUT_PIN_OUT(pin), .IRQ_OUT(irq));

  btg_buzzer_model btg_buzzer_model_i (.clk_in(clk), .pin_in(pin), .period_out(period),
    .high_out(high), .rises_out(rises));

  task automatic summarize();
    if (failures == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  always @(posedge clk) begin
    cycles++;
    if (cycles == 130000) begin
      failures++;
      summarize();
    end
  end

  // strobe dropped and an edge let pass, so back-to-back calls never collide
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : rd

  // core cycles to 1/65536 s units, rounded
  function automatic int units(input int c);
    units = int'((longint'(c) * 65536 + 10000000) / 20000000);
  endfunction : units

  task automatic wait_rise2();
    while (rises < r0 + 2) @(posedge clk);
  endtask : wait_rise2

  task automatic meas(input logic [2:0] f, input logic [2:0] dd);
    int base;
    base = f[1] ? 12 : 8;
    wr(FREQ_ADDR, {1'b0, dd, 1'b0, f});
    r0 = rises;
    wr(CTRL_ADDR, 8'h01);
    wait_rise2();
    check(units(period), 2 * dv[f]);
    check(units(high), (base - dd) * (f[2] ? 2 : 1));
    wr(CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clk);
  endtask : meas

  // software waits for ready before any new trigger
  task automatic poll(output int c);
    int t0;
    logic [7:0] v;
    t0 = cycles;
    do rd(CTRL_ADDR, v); while (v[5] !== 1'b0 && cycles - t0 < 5000);
    c = cycles - t0;
  endtask : poll

  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 9000) begin
      @(posedge clk);
      c++;
    end
  endtask : wait_irq

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) begin
      rd(CTRL_ADDR + 16'(i), d);
      check(d, 8'h00);
    end
    check(irq, 1'b0);
    check(pin, 1'b0);
    wr(CTRL_ADDR, 8'h9a);
    rd(CTRL_ADDR, d);
    check(d, 8'h1a);
    wr(FREQ_ADDR, 8'hff);
    rd(FREQ_ADDR, d);
    check(d, 8'h77);
    wr(CTRL_ADDR, 8'h00);
    r0 = rises;
    wr(CTRL_ADDR, 8'h01);
    // long enough for a rise even at the slowest code
    repeat (1000) @(posedge clk);
    check(rises, r0);
    wr(CTRL_ADDR, 8'h00);
    port <= 1'b1;
    for (int f = 0; f < 8; f++) meas(f[2:0], f[2:0]);
    wr(FREQ_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h20);
    rd(CTRL_ADDR, d);
    check(d, 8'h20);
    poll(n);
    check(n >= 280 && n <= 640, 1'b1);
    check(irq, 1'b0);
    wr(MASK_ADDR, 8'h01);
    check(irq, 1'b1);
    rd(STAT_ADDR, d);
    check(d, 8'h01);
    check(irq, 1'b0);
    wr(CTRL_ADDR, 8'h12);
    r0 = rises;
    wr(CTRL_ADDR, 8'h32);
    rd(CTRL_ADDR, d);
    check(d, 8'h30);
    poll(n);
    check(n >= 2090 && n <= 2470, 1'b1);
    check(rises, r0 + 1);
    // clear the expiry event so the stop below must set it alone
    rd(STAT_ADDR, d);
    check(d, 8'h01);
    wr(CTRL_ADDR, 8'h30);
    repeat (200) @(posedge clk);
    wr(CTRL_ADDR, 8'h50);
    rd(CTRL_ADDR, d);
    check(d, 8'h10);
    rd(STAT_ADDR, d);
    check(d, 8'h01);
    wr(MASK_ADDR, 8'h02);
    wr(CTRL_ADDR, 8'h03);
    wait_irq(n);
    check(n >= 3900 && n <= 4600, 1'b1);
    rd(STAT_ADDR, d);
    check(d, 8'h02);
    r0 = rises;
    wait_rise2();
    check(units(high), 1);
    wr(CTRL_ADDR, 8'h00);
    wr(CTRL_ADDR, 8'h0b);
    repeat (1000) @(posedge clk);
    check(irq, 1'b0);
    wr(CTRL_ADDR, 8'h0f);
    wait_irq(n);
    check(n >= 6100 && n <= 6750, 1'b1);
    rd(CTRL_ADDR, d);
    check(d, 8'h0b);
    wr(CTRL_ADDR, 8'h00);
    summarize();
  end
endmodule : tb_buzzer_tone_generator
